//--- core/gfs_cfg.svh
/*
  Constants of the general-purpose pin function select block: command codes,
  field positions, reset values and reboot timing.
  Assumes inclusion by bare name from the top module and the testbench.
*/
// Behaviour
// - Pins 1-4 route register, reset 5F43.
// - Pins 5-8 route register, reset 8207.
// - Input-select reserved bits always read zero.
// - Enabled trigger turns switches off, waits, restores.
// - Reboot-pin field bits 6:4 picks trigger pin.
// - Comparator field bits 2:0 routes pin, reset 101.
// - Four-bit selector decodes each pin's output source.
`ifndef GFS_CFG_SVH
`define GFS_CFG_SVH

`define GFS_CMD_ROUTE_LOW   8'hF5
`define GFS_CMD_ROUTE_HIGH  8'hF6
`define GFS_CMD_IN_ROUTE    8'hF7

`define GFS_ROUTE_LOW_RST   16'h5F43
`define GFS_ROUTE_HIGH_RST  16'h8207
`define GFS_IN_ROUTE_RST    16'h0005

`define GFS_EN_BIT          7
`define GFS_RBT_MSB         6
`define GFS_RBT_LSB         4
`define GFS_CMP_MSB         2
`define GFS_CMP_LSB         0
`define GFS_IN_ROUTE_MASK   16'h00F7

`define GFS_CLK_MHZ         250
`define GFS_TRIG_MIN_US     50
`define GFS_RBT_DL0_MS      17'h00244
`define GFS_RBT_DL1_MS      17'h00488
`define GFS_RBT_DL2_MS      17'h00910
`define GFS_RBT_DL3_MS      17'h01220
`define GFS_RBT_DL4_MS      17'h02440
`define GFS_RBT_DL5_MS      17'h048A8
`define GFS_RBT_DL6_MS      17'h090EC
`define GFS_RBT_DL7_MS      17'h121D8

`endif

//--- core/gfs_pkg.sv
/*
  Types of the general-purpose pin function select block.
  Assumes gfs_cfg.svh is on the include path.
*/
package gfs_pkg;

  typedef enum logic [3:0] {
    GFS_SRC_TRISTATE = 4'h0,
    GFS_SRC_DATA     = 4'h1,
    GFS_SRC_COMP     = 4'h2,
    GFS_SRC_PGOOD    = 4'h3,
    GFS_SRC_FAULT    = 4'h4,
    GFS_SRC_OVERCUR  = 4'h5,
    GFS_SRC_OPSTAT   = 4'h8,
    GFS_SRC_ALERT    = 4'h9,
    GFS_SRC_LALERT   = 4'hA,
    GFS_SRC_TEMP     = 4'hF
  } gfs_src_e;

  typedef enum logic [1:0] {
    GFS_ST_ON  = 2'b01,
    GFS_ST_OFF = 2'b10
  } gfs_state_e;

  typedef logic [7:0] gfs_pins_t;

endpackage

//--- core/gfs_src_if.sv
/*
  Bundle of internal signal sources offered to every pin output selector.
  Assumes one driver, the top module, and any number of selectors reading.
*/
`timescale 1ns/10ps
`default_nettype none

interface gfs_src_if;
  logic       comparator_output;
  logic       power_good;
  logic       fault;
  logic       overcurrent_status;
  logic       operating_status;
  logic       alert;
  logic       latched_alert;
  logic       temp_sensor;
  logic [7:0] pin_output_data;

  modport source (output comparator_output, power_good, fault, overcurrent_status,
                  operating_status, alert, latched_alert, temp_sensor, pin_output_data);
  modport sink   (input  comparator_output, power_good, fault, overcurrent_status,
                  operating_status, alert, latched_alert, temp_sensor, pin_output_data);
endinterface

`default_nettype wire

//--- core/gfs_pin_mux.sv
/*
  Output selector of one general-purpose pin: decodes a 4-bit source code into
  a registered pin level and an active-low output enable.
  Assumes the clock and synchronous reset of the top module.
*/
`timescale 1ns/10ps
`default_nettype none

module gfs_pin_mux
  import gfs_pkg::*;
#(
  parameter int PIN_IDX = 0
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [3:0] source_sel,
  gfs_src_if.sink         src,
  output logic            pin_out_q,
  output logic            pin_oe_n_q
);

  logic pin_out_d;
  logic pin_oe_n_d;

  // Reserved and unknown codes float the pin so a stray write never drives the board.
  always_comb begin
    pin_out_d  = 1'b0;
    pin_oe_n_d = 1'b0;
    unique case (source_sel)
      GFS_SRC_DATA:    pin_out_d = src.pin_output_data[PIN_IDX];
      GFS_SRC_COMP:    pin_out_d = src.comparator_output;
      GFS_SRC_PGOOD:   pin_out_d = src.power_good;
      GFS_SRC_FAULT:   pin_out_d = src.fault;
      GFS_SRC_OVERCUR: pin_out_d = src.overcurrent_status;
      GFS_SRC_OPSTAT:  pin_out_d = src.operating_status;
      GFS_SRC_ALERT:   pin_out_d = src.alert;
      GFS_SRC_LALERT:  pin_out_d = src.latched_alert;
      GFS_SRC_TEMP: begin
        if (PIN_IDX == 2) begin
          pin_out_d = src.temp_sensor;
        end else begin
          pin_oe_n_d = 1'b1;
        end
      end
      default:         pin_oe_n_d = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_out_q  <= pin_out_d;
      pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_tristate_code;
    @(posedge clock) disable iff (rst)
      (source_sel == 4'h0) |=> pin_oe_n_q;
  endproperty
  a_tristate_code: assert property (p_tristate_code) else $error("Code 0 did not float the pin.");

  property p_data_code;
    @(posedge clock) disable iff (rst)
      (source_sel == 4'h1) |=> (!pin_oe_n_q && pin_out_q == $past(src.pin_output_data[PIN_IDX]));
  endproperty
  a_data_code: assert property (p_data_code) else $error("Code 1 did not drive the data bit.");

  c_comp_code: cover property (@(posedge clock) disable iff (rst)
    source_sel == 4'h2 ##1 !pin_oe_n_q);

endmodule

`default_nettype wire

//--- core/gfs_top.sv
/*
  General-purpose pin function select: three command registers reached by
  command code, eight pin output selectors, comparator input routing and the
  pin-triggered reboot sequencer.
  Assumes a command engine that presents one decoded command per strobe and
  pins sampled synchronously to the clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gfs_cfg.svh"

module gfs_top
  import gfs_pkg::*;
#(
  parameter int MS_CYCLES = `GFS_CLK_MHZ * 1000
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]      cmd_rdata_q,
  output logic             cmd_rvalid_q,
  output logic             cmd_unmapped_q,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out_q,
  output logic [7:0]       pin_oe_n_q,
  input  wire logic        comparator_output,
  input  wire logic        power_good,
  input  wire logic        fault,
  input  wire logic        overcurrent_status,
  input  wire logic        operating_status,
  input  wire logic        alert,
  input  wire logic        latched_alert,
  input  wire logic        temp_sensor,
  input  wire logic [7:0]  pin_output_data,
  input  wire logic        reboot_trigger_polarity,
  input  wire logic [2:0]  reboot_delay_sel,
  output logic             comparator_input_q,
  output logic             switches_on_q,
  output logic             reboot_active_q
);

  // ****************************************************************
  // Command registers
  // ****************************************************************
  logic [15:0] route_low_q,  route_low_d;
  logic [15:0] route_high_q, route_high_d;
  logic [15:0] in_route_q,   in_route_d;
  logic [15:0] cmd_rdata_d;
  logic        cmd_rvalid_d;
  logic        cmd_unmapped_d;
  logic        mapped;

  always_comb begin
    route_low_d    = route_low_q;
    route_high_d   = route_high_q;
    in_route_d     = in_route_q;
    cmd_rdata_d    = 16'h0000;
    cmd_rvalid_d   = cmd_rd;
    mapped         = (cmd_code == `GFS_CMD_ROUTE_LOW) || (cmd_code == `GFS_CMD_ROUTE_HIGH) ||
                     (cmd_code == `GFS_CMD_IN_ROUTE);
    cmd_unmapped_d = (cmd_rd || cmd_wr) && !mapped;
    if (cmd_wr) begin
      unique case (cmd_code)
        `GFS_CMD_ROUTE_LOW:  route_low_d  = cmd_wdata;
        `GFS_CMD_ROUTE_HIGH: route_high_d = cmd_wdata;
        `GFS_CMD_IN_ROUTE:   in_route_d   = cmd_wdata & `GFS_IN_ROUTE_MASK;
        default: ;
      endcase
    end
    if (cmd_rd) begin
      unique case (cmd_code)
        `GFS_CMD_ROUTE_LOW:  cmd_rdata_d = route_low_q;
        `GFS_CMD_ROUTE_HIGH: cmd_rdata_d = route_high_q;
        `GFS_CMD_IN_ROUTE:   cmd_rdata_d = in_route_q & `GFS_IN_ROUTE_MASK;
        default:             cmd_rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      route_low_q    <= `GFS_ROUTE_LOW_RST;
      route_high_q   <= `GFS_ROUTE_HIGH_RST;
      in_route_q     <= `GFS_IN_ROUTE_RST;
      cmd_rdata_q    <= 16'h0000;
      cmd_rvalid_q   <= 1'b0;
      cmd_unmapped_q <= 1'b0;
    end else begin
      route_low_q    <= route_low_d;
      route_high_q   <= route_high_d;
      in_route_q     <= in_route_d;
      cmd_rdata_q    <= cmd_rdata_d;
      cmd_rvalid_q   <= cmd_rvalid_d;
      cmd_unmapped_q <= cmd_unmapped_d;
    end
  end

  logic       pin_reboot_enable;
  logic [2:0] reboot_pin_choice;
  logic [2:0] comparator_pin_choice;
  assign pin_reboot_enable     = in_route_q[`GFS_EN_BIT];
  assign reboot_pin_choice     = in_route_q[`GFS_RBT_MSB:`GFS_RBT_LSB];
  assign comparator_pin_choice = in_route_q[`GFS_CMP_MSB:`GFS_CMP_LSB];

  // ****************************************************************
  // Pin output selectors
  // ****************************************************************
  gfs_src_if src_bus ();
  assign src_bus.comparator_output  = comparator_output;
  assign src_bus.power_good         = power_good;
  assign src_bus.fault              = fault;
  assign src_bus.overcurrent_status = overcurrent_status;
  assign src_bus.operating_status   = operating_status;
  assign src_bus.alert              = alert;
  assign src_bus.latched_alert      = latched_alert;
  assign src_bus.temp_sensor        = temp_sensor;
  assign src_bus.pin_output_data    = pin_output_data;

  logic [31:0] route_all;
  assign route_all = {route_high_q, route_low_q};

  for (genvar i = 0; i < 8; i++) begin : g_pin
    gfs_pin_mux #(.PIN_IDX(i)) u_mux (
      .clock      (clock),
      .rst        (rst),
      .source_sel (route_all[4*i +: 4]),
      .src        (src_bus.sink),
      .pin_out_q  (pin_out_q[i]),
      .pin_oe_n_q (pin_oe_n_q[i])
    );
  end

  // ****************************************************************
  // Input routing and reboot trigger
  // ****************************************************************
  logic comparator_input_d;
  logic trig_level_q, trig_level_d;
  logic trig_edge;

  // Code n selects pin n+1 for both fields, so index the pin vector directly.
  always_comb begin
    comparator_input_d = pin_in[comparator_pin_choice];
    trig_level_d       = pin_in[reboot_pin_choice] ^ reboot_trigger_polarity;
  end

  // A change of polarity or pin choice can look like an edge; software should
  // clear the enable while it reprograms the trigger.
  assign trig_edge = trig_level_d && !trig_level_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      comparator_input_q <= 1'b0;
      trig_level_q       <= 1'b0;
    end else begin
      comparator_input_q <= comparator_input_d;
      trig_level_q       <= trig_level_d;
    end
  end

  // ****************************************************************
  // Reboot sequencer
  // ****************************************************************
  gfs_state_e  state_q, state_d;
  logic [31:0] tick_cnt_q, tick_cnt_d;
  logic [16:0] ms_cnt_q, ms_cnt_d;
  logic [16:0] delay_ms;
  logic        ms_tick;

  always_comb begin
    unique case (reboot_delay_sel)
      3'h0: delay_ms = `GFS_RBT_DL0_MS;
      3'h1: delay_ms = `GFS_RBT_DL1_MS;
      3'h2: delay_ms = `GFS_RBT_DL2_MS;
      3'h3: delay_ms = `GFS_RBT_DL3_MS;
      3'h4: delay_ms = `GFS_RBT_DL4_MS;
      3'h5: delay_ms = `GFS_RBT_DL5_MS;
      3'h6: delay_ms = `GFS_RBT_DL6_MS;
      3'h7: delay_ms = `GFS_RBT_DL7_MS;
    endcase
  end

  assign ms_tick = (tick_cnt_q == 32'(MS_CYCLES - 1));

  always_comb begin
    state_d    = state_q;
    tick_cnt_d = 32'h0000_0000;
    ms_cnt_d   = ms_cnt_q;
    unique case (state_q)
      GFS_ST_ON: begin
        if (pin_reboot_enable && trig_edge) begin
          state_d  = GFS_ST_OFF;
          ms_cnt_d = delay_ms;
        end
      end
      GFS_ST_OFF: begin
        tick_cnt_d = ms_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
        if (ms_tick) begin
          ms_cnt_d = ms_cnt_q - 17'h00001;
          if (ms_cnt_q == 17'h00001) begin
            state_d = GFS_ST_ON;
          end
        end
      end
      default: state_d = GFS_ST_ON;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q         <= GFS_ST_ON;
      tick_cnt_q      <= 32'h0000_0000;
      ms_cnt_q        <= 17'h00000;
      switches_on_q   <= 1'b1;
      reboot_active_q <= 1'b0;
    end else begin
      state_q         <= state_d;
      tick_cnt_q      <= tick_cnt_d;
      ms_cnt_q        <= ms_cnt_d;
      switches_on_q   <= (state_d == GFS_ST_ON);
      reboot_active_q <= (state_d == GFS_ST_OFF);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_low_reset;
    @(posedge clock) rst |=> (route_low_q == 16'h5F43);
  endproperty
  a_low_reset: assert property (p_low_reset) else $error("Low route register reset value wrong.");

  property p_high_write;
    @(posedge clock) disable iff (rst)
      (cmd_wr && cmd_code == 8'hF6) |=> (route_high_q == $past(cmd_wdata));
  endproperty
  a_high_write: assert property (p_high_write) else $error("High route register write lost.");

  property p_reserved_zero;
    @(posedge clock) disable iff (rst)
      (cmd_rd && cmd_code == 8'hF7) |=> (cmd_rvalid_q && (cmd_rdata_q & 16'hFF08) == 16'h0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved input bits read nonzero.");

  property p_reboot_off;
    @(posedge clock) disable iff (rst)
      (state_q == GFS_ST_ON && pin_reboot_enable && trig_edge) |=> ##1 (!switches_on_q && reboot_active_q);
  endproperty
  a_reboot_off: assert property (p_reboot_off) else $error("Trigger did not turn switches off.");

  property p_reboot_disabled;
    @(posedge clock) disable iff (rst)
      (state_q == GFS_ST_ON && !pin_reboot_enable) |=> (state_q == GFS_ST_ON);
  endproperty
  a_reboot_disabled: assert property (p_reboot_disabled) else $error("Reboot started while disabled.");

  property p_trig_pin;
    @(posedge clock) disable iff (rst)
      1'b1 |=> (trig_level_q == ($past(pin_in[reboot_pin_choice]) ^ $past(reboot_trigger_polarity)));
  endproperty
  a_trig_pin: assert property (p_trig_pin) else $error("Reboot trigger sampled from wrong pin.");

  property p_comp_pin;
    @(posedge clock) disable iff (rst)
      (comparator_pin_choice == 3'h5) |=> (comparator_input_q == $past(pin_in[5]));
  endproperty
  a_comp_pin: assert property (p_comp_pin) else $error("Comparator not routed from pin 6.");

  property p_restore;
    @(posedge clock) disable iff (rst)
      (state_q == GFS_ST_OFF && ms_tick && ms_cnt_q == 17'h00001) |=> ##1 switches_on_q;
  endproperty
  a_restore: assert property (p_restore) else $error("Switches not restored after delay.");

  c_reboot: cover property (@(posedge clock) disable iff (rst) $rose(reboot_active_q));
  c_restore: cover property (@(posedge clock) disable iff (rst) $rose(switches_on_q));
  c_unmapped: cover property (@(posedge clock) disable iff (rst) cmd_unmapped_q);

endmodule

`default_nettype wire

//--- testbench/gfs_board_model.sv
/*
  Board logic at the eight general-purpose pins: resolves each pin's level and
  can drive pins, including a held reboot trigger pulse.
  Assumes the bench calls its tasks and shares the device clock.
*/
`timescale 1ns/10ps
`default_nettype none

module gfs_board_model #(
  parameter int HOLD_CYCLES = 12500
) (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  output logic      [7:0] pin_in
);
  logic [7:0] drv_en;
  logic [7:0] drv_lvl;

  initial begin
    drv_en = 8'h00;
    drv_lvl = 8'h00;
  end

  // An undriven pin falls to its pull-down, so a release never makes a rising edge.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (drv_en[i] ? drv_lvl[i] : 1'b0);
    end
  end

  task automatic drive_all(input logic [7:0] lvl);
    @(negedge clock);
    drv_en = 8'hFF;
    drv_lvl = lvl;
  endtask

  // The trigger is held for exactly the minimum time, the tightest case a board may present.
  task automatic pulse(input int idx);
    drive_all(8'h00);
    @(negedge clock);
    drv_lvl[idx] = 1'b1;
    repeat (HOLD_CYCLES) @(negedge clock);
    drv_lvl[idx] = 1'b0;
  endtask
endmodule

`default_nettype wire

//--- testbench/gpio_function_select_tb.sv
/*
  Self-checking bench of the pin function select block: registers, selector
  decode, comparator routing and pin-triggered reboot.
  Assumes gfs_cfg.svh on the include path and the board model alongside.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gfs_cfg.svh"

module gpio_function_select_tb;
  import gfs_pkg::*;
  localparam int MS = 4;
  logic clock, rst, cmd_wr, cmd_rd, cmd_rvalid_q, cmd_unmapped_q;
  logic [7:0] cmd_code, pin_in, pin_out_q, pin_oe_n_q, pin_output_data;
  logic [15:0] cmd_wdata, cmd_rdata_q;
  logic comparator_output, power_good, fault, overcurrent_status, operating_status;
  logic alert, latched_alert, temp_sensor, polarity, comparator_input_q, switches_on_q, reboot_active_q;
  logic [2:0] delay_sel;
  int n_fail, total_checks, off_cnt, act_cnt;
  logic cnt_clr;

  gfs_top #(.MS_CYCLES(MS)) dut_u (
    .clock(clock), .rst(rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q),
    .cmd_unmapped_q(cmd_unmapped_q), .pin_in(pin_in), .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
    .comparator_output(comparator_output), .power_good(power_good), .fault(fault),
    .overcurrent_status(overcurrent_status), .operating_status(operating_status), .alert(alert),
    .latched_alert(latched_alert), .temp_sensor(temp_sensor), .pin_output_data(pin_output_data),
    .reboot_trigger_polarity(polarity), .reboot_delay_sel(delay_sel),
    .comparator_input_q(comparator_input_q), .switches_on_q(switches_on_q), .reboot_active_q(reboot_active_q));

  gfs_board_model board_u (.clock(clock), .pin_out(pin_out_q), .pin_oe_n(pin_oe_n_q), .pin_in(pin_in));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // The counters are cleared through a request flag so that only this process writes them.
  always @(posedge clock) begin
    off_cnt <= cnt_clr ? 0 : off_cnt + (switches_on_q !== 1'b1);
    act_cnt <= cnt_clr ? 0 : act_cnt + (reboot_active_q === 1'b1);
  end

  task automatic clr_cnt();
    cnt_clr = 1'b1;
    @(negedge clock);
    cnt_clr = 1'b0;
  endtask

  // A run that ran out of time passes one extra mismatch in, so n_fail keeps one writer.
  task automatic end_sim(input int extra);
    $display("checks %0d mismatches %0d", total_checks, n_fail + extra);
    if (n_fail + extra == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmd_write(input logic [7:0] code, input logic [15:0] data);
    @(negedge clock);
    cmd_wr = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge clock);
    cmd_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic unm);
    @(negedge clock);
    cmd_rd = 1'b1;
    cmd_code = code;
    @(negedge clock);
    cmd_rd = 1'b0;
    check("rvalid", 16'h0001, {15'h0000, cmd_rvalid_q});
    check("rdata", exp, cmd_rdata_q);
    check("unmapped", {15'h0000, unm}, {15'h0000, cmd_unmapped_q});
  endtask

  // Drives every source to the inverse of v, then the one picked by code c to v.
  task automatic set_src(input int c, input logic v);
    @(negedge clock);
    {comparator_output, power_good, fault, overcurrent_status} = {4{~v}};
    {operating_status, alert, latched_alert, temp_sensor} = {4{~v}};
    pin_output_data = {8{~v}};
    case (c)
      1: pin_output_data[0] = v;
      2: comparator_output = v;
      3: power_good = v;
      4: fault = v;
      5: overcurrent_status = v;
      8: operating_status = v;
      9: alert = v;
      10: latched_alert = v;
      15: temp_sensor = v;
      default: ;
    endcase
    repeat (2) @(negedge clock);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset_and_map();
    check("oe after reset", 16'h0030, {8'h00, pin_oe_n_q});
    rd_chk(`GFS_CMD_ROUTE_LOW, 16'h5F43, 1'b0);
    rd_chk(`GFS_CMD_ROUTE_HIGH, 16'h8207, 1'b0);
    rd_chk(`GFS_CMD_IN_ROUTE, 16'h0005, 1'b0);
    cmd_write(8'hF8, 16'hFFFF);
    rd_chk(8'hF4, 16'h0000, 1'b1);
    rd_chk(`GFS_CMD_ROUTE_LOW, 16'h5F43, 1'b0);
    cmd_write(`GFS_CMD_IN_ROUTE, 16'hFFFF);
    rd_chk(`GFS_CMD_IN_ROUTE, 16'h00F7, 1'b0);
    cmd_write(`GFS_CMD_IN_ROUTE, 16'h0005);
    $display("test reset_and_map done");
  endtask

  task automatic t_decode();
    logic drv;
    for (int c = 0; c < 16; c++) begin
      cmd_write(`GFS_CMD_ROUTE_LOW, {12'h000, 4'(c)});
      drv = (c inside {1, 2, 3, 4, 5, 8, 9, 10});
      for (int v = 0; v < 2; v++) begin
        set_src(c, 1'(v));
        check("pin1 oe", {15'h0000, ~drv}, {15'h0000, pin_oe_n_q[0]});
        if (drv) check("pin1 level", 16'(v), {15'h0000, pin_out_q[0]});
      end
    end
    cmd_write(`GFS_CMD_ROUTE_LOW, 16'h0FF0);
    for (int v = 0; v < 2; v++) begin
      set_src(15, 1'(v));
      check("pin3 temp", 16'(v), {15'h0000, pin_out_q[2]});
      check("pin2 oe", 16'h0001, {15'h0000, pin_oe_n_q[1]});
    end
    cmd_write(`GFS_CMD_ROUTE_LOW, 16'h1111);
    cmd_write(`GFS_CMD_ROUTE_HIGH, 16'h1111);
    pin_output_data = 8'hA5;
    repeat (2) @(negedge clock);
    check("data pins", 16'h00A5, {8'h00, pin_out_q});
    check("data oe", 16'h0000, {8'h00, pin_oe_n_q});
    cmd_write(`GFS_CMD_ROUTE_HIGH, 16'h0010);
    repeat (2) @(negedge clock);
    check("pin6 only", 16'h00D0, {8'h00, pin_oe_n_q});
    $display("test decode done");
  endtask

  task automatic t_comparator();
    cmd_write(`GFS_CMD_ROUTE_LOW, 16'h0000);
    cmd_write(`GFS_CMD_ROUTE_HIGH, 16'h0000);
    for (int c = 0; c < 8; c++) begin
      cmd_write(`GFS_CMD_IN_ROUTE, 16'(c));
      board_u.drive_all(8'h01 << c);
      repeat (3) @(negedge clock);
      check("comparator high", 16'h0001, {15'h0000, comparator_input_q});
      board_u.drive_all(~(8'h01 << c));
      repeat (3) @(negedge clock);
      check("comparator low", 16'h0000, {15'h0000, comparator_input_q});
    end
    $display("test comparator done");
  endtask

  task automatic t_reboot();
    int exp;
    exp = 1160 * MS;
    delay_sel = 3'h1;
    cmd_write(`GFS_CMD_IN_ROUTE, 16'h0035);
    clr_cnt();
    board_u.pulse(3);
    check("off when disabled", 16'h0000, 16'(off_cnt));
    cmd_write(`GFS_CMD_IN_ROUTE, 16'h00B5);
    board_u.pulse(4);
    check("off on other pin", 16'h0000, 16'(off_cnt));
    board_u.pulse(3);
    check("off length", 16'(exp), 16'(off_cnt));
    check("active length", 16'(exp), 16'(act_cnt));
    check("switches back on", 16'h0001, {15'h0000, switches_on_q});
    // Polarity changes with the trigger disabled, since the change alone looks like an edge.
    cmd_write(`GFS_CMD_IN_ROUTE, 16'h0035);
    polarity = 1'b1;
    delay_sel = 3'h0;
    exp = 580 * MS;
    cmd_write(`GFS_CMD_IN_ROUTE, 16'h00B5);
    clr_cnt();
    board_u.pulse(3);
    check("off before falling edge", 16'h0000, 16'(off_cnt));
    repeat (exp + 4) @(negedge clock);
    check("off length falling", 16'(exp), 16'(off_cnt));
    check("switches on after falling", 16'h0001, {15'h0000, switches_on_q});
    $display("test reboot done");
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    repeat (100000) @(posedge clock);
    end_sim(1);
  end

  initial begin
    {rst, cmd_wr, cmd_rd, polarity} = 4'h8;
    {cmd_code, cmd_wdata, delay_sel} = '0;
    {comparator_output, power_good, fault, overcurrent_status} = 4'h0;
    {operating_status, alert, latched_alert, temp_sensor} = 4'h0;
    pin_output_data = 8'h00;
    {n_fail, total_checks} = '0;
    cnt_clr = 1'b1;
    repeat (5) @(negedge clock);
    rst = 1'b0;
    cnt_clr = 1'b0;
    repeat (2) @(negedge clock);
    t_reset_and_map();
    t_decode();
    t_comparator();
    t_reboot();
    end_sim(0);
  end
endmodule

`default_nettype wire
